//--- rtl/bsr_boot_ctrl.sv
// Boot source selection and reset sequencer.
// Assumes loader engines answer a start with one done or fail pulse.
//
// How it works
// R1: Code F00 boots sync 16-bit muxed port; F01 the async muxed port.
// R2: Code F0F boots through the async SRAM-style 16-bit parallel port.
// R3: Code F11 takes the image only by USB download.
// R4: F1F boots from I2C with USB fallback; 1FF boots I2C only.
// R5: Code 0F1 boots from SPI flash, falling back to USB on failure.
// R6: SPI boot accepts 16, 8 or 4 megabit flash; others count as failure.
// R7: I2C boot runs the I2C port as master reading an EEPROM.
// R8: External logic starts a hard reset by pulling rst_n low.
// R9: Soft reset comes from port init control bits: CPU-only or whole device.
// R10: CPU reset restarts the processor and keeps loaded firmware.
// R11: Whole device reset acts as hard reset; firmware reloads.
// R12: USB boot enumerates with default identity and accepts downloaded image.
// R13: After download, disconnect then reconnect with the downloaded identity.
// R14: Straps are decoded once on reset release and held until next reset.
`timescale 1ns/1ps

module bsr_boot_ctrl #(
  parameter logic [15:0] DEFAULT_VID = 16'h1234, // arbitrary value
  parameter int DISC_CYC = bsr_pkg::USB_DISC_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Boot-mode strap pads
  input wire logic [2:0] strapIn,
  output logic [2:0] strapPullUp,
  output logic [2:0] strapPullDown,
  // Port init control soft reset bits
  input wire logic portInitCpuReset,
  input wire logic portInitDeviceReset,
  // Loader engines
  output bsr_pkg::bsr_load_req_s loadReq,
  input wire bsr_pkg::bsr_load_rsp_s loadRsp,
  output logic i2cMasterOnly,
  // USB link control
  output bsr_pkg::bsr_usb_s usbCtl,
  // Status to the core
  output logic cpuHold,
  output logic firmwareValid,
  output logic [5:0] bootCode,
  output logic bootHalted
);

  // ****************************************************************
  // Sequencer state
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_PULL_UP   = 3'h0,
    ST_PULL_DOWN = 3'h1,
    ST_DECODE    = 3'h2,
    ST_LOAD      = 3'h3,
    ST_DISC      = 3'h4,
    ST_RUN       = 3'h5,
    ST_HALT      = 3'h6
  } bsr_state_e;

  bsr_state_e state;
  bsr_state_e next_state;
  logic [bsr_pkg::CNT_W-1:0] cnt;
  logic cntDone;
  logic [5:0] levels;
  bsr_pkg::bsr_src_e src;
  bsr_pkg::bsr_src_e next_src;
  logic usbFallback;
  logic next_usbFallback;
  logic loadFail;
  logic spiOk;
  logic [3:0] cpuRstCnt;

  localparam logic [bsr_pkg::CNT_W-1:0] SETTLE =
    bsr_pkg::CNT_W'(bsr_pkg::STRAP_SETTLE_CYC - 1);
  localparam logic [bsr_pkg::CNT_W-1:0] DISC =
    bsr_pkg::CNT_W'(DISC_CYC - 1);
  localparam logic [3:0] CPU_RST = 4'(bsr_pkg::CPU_RST_CYC);

  assign cntDone = (cnt == '0);

  // ****************************************************************
  // Strap sensing
  // ****************************************************************
  bsr_strap_sense #(
    .PINS(3)
  ) u_sense (
    .mclk(mclk),
    .rst_n(rst_n),
    .phaseUp(state == ST_PULL_UP),
    .phaseDown(state == ST_PULL_DOWN),
    .sampleUp(state == ST_PULL_UP && cntDone),
    .sampleDown(state == ST_PULL_DOWN && cntDone),
    .strapIn(strapIn),
    .strapPullUp(strapPullUp),
    .strapPullDown(strapPullDown),
    .levels(levels)
  );

  // Code held from decode until the next hard or whole device reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bootCode <= 6'h00;
    end else if (portInitDeviceReset) begin
      bootCode <= 6'h00; // [R11]
    end else if (state == ST_DECODE) begin
      bootCode <= levels; // [R14]
    end
  end

  // ****************************************************************
  // Decode and failure checks
  // ****************************************************************
  always_comb begin
    next_src = bsr_pkg::SRC_NONE;
    next_usbFallback = 1'b0;
    unique case (levels)
      bsr_pkg::CODE_SYNC_MUX: next_src = bsr_pkg::SRC_SYNC_MUX; // [R1]
      bsr_pkg::CODE_ASYNC_MUX: next_src = bsr_pkg::SRC_ASYNC_MUX; // [R1]
      bsr_pkg::CODE_SRAM: next_src = bsr_pkg::SRC_SRAM; // [R2]
      bsr_pkg::CODE_USB: next_src = bsr_pkg::SRC_USB; // [R3]
      bsr_pkg::CODE_I2C_USB: begin
        next_src = bsr_pkg::SRC_I2C; // [R4]
        next_usbFallback = 1'b1;
      end
      bsr_pkg::CODE_I2C_ONLY: next_src = bsr_pkg::SRC_I2C; // [R4]
      bsr_pkg::CODE_SPI_USB: begin
        next_src = bsr_pkg::SRC_SPI; // [R5]
        next_usbFallback = 1'b1;
      end
      default: next_src = bsr_pkg::SRC_NONE;
    endcase
  end

  // Unknown flash sizes would misread the image, so they fall back
  assign spiOk = loadRsp.spiMbit == bsr_pkg::SPI_MBIT_4 ||
                 loadRsp.spiMbit == bsr_pkg::SPI_MBIT_8 ||
                 loadRsp.spiMbit == bsr_pkg::SPI_MBIT_16; // [R6]
  assign loadFail = loadRsp.fail ||
                    (loadRsp.done && src == bsr_pkg::SRC_SPI && !spiOk);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      ST_PULL_UP: if (cntDone) begin
        next_state = ST_PULL_DOWN;
      end
      ST_PULL_DOWN: if (cntDone) begin
        next_state = ST_DECODE;
      end
      ST_DECODE: begin
        next_state = (next_src == bsr_pkg::SRC_NONE) ? ST_HALT : ST_LOAD;
      end
      ST_LOAD: begin
        if (loadFail) begin
          next_state = usbFallback ? ST_LOAD : ST_HALT; // [R4] [R5]
        end else if (loadRsp.done) begin
          next_state = (src == bsr_pkg::SRC_USB) ? ST_DISC : ST_RUN; // [R13]
        end
      end
      ST_DISC: if (cntDone) begin
        next_state = ST_RUN;
      end
      ST_RUN: next_state = ST_RUN;
      ST_HALT: next_state = ST_HALT;
      default: next_state = ST_HALT;
    endcase
    if (portInitDeviceReset) begin
      next_state = ST_PULL_UP; // [R9] [R11]
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_PULL_UP; // [R8]
    end else begin
      state <= next_state;
    end
  end

  // Wait counter reloads on every state change
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= SETTLE;
    end else if (next_state != state || portInitDeviceReset) begin
      cnt <= (next_state == ST_DISC) ? DISC : SETTLE;
    end else if (!cntDone) begin
      cnt <= cnt - 1'b1;
    end
  end

  // ****************************************************************
  // Selected source and loader request
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      src <= bsr_pkg::SRC_NONE;
      usbFallback <= 1'b0;
    end else if (portInitDeviceReset) begin
      src <= bsr_pkg::SRC_NONE;
      usbFallback <= 1'b0;
    end else if (state == ST_DECODE) begin
      src <= next_src;
      usbFallback <= next_usbFallback;
    end else if (state == ST_LOAD && loadFail && usbFallback) begin
      src <= bsr_pkg::SRC_USB; // [R4] [R5]
      usbFallback <= 1'b0;
    end
  end

  // One start pulse per attempt, including the USB retry
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      loadReq <= '0;
    end else begin
      loadReq.start <= !portInitDeviceReset && next_state == ST_LOAD &&
                       (state == ST_DECODE || loadFail);
      // Cleared with the soft reset so it never lags the selected source
      if (portInitDeviceReset) begin
        loadReq.src <= bsr_pkg::SRC_NONE;
      end else if (next_state == ST_LOAD && state == ST_DECODE) begin
        loadReq.src <= next_src;
      end else if (state == ST_LOAD && loadFail && usbFallback) begin
        loadReq.src <= bsr_pkg::SRC_USB;
      end else begin
        loadReq.src <= src;
      end
    end
  end

  assign i2cMasterOnly = (src == bsr_pkg::SRC_I2C); // [R7]
  assign bootHalted = (state == ST_HALT);

  // ****************************************************************
  // USB identity and connect
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      usbCtl.connect <= 1'b0;
      usbCtl.downloadedId <= 1'b0;
      // Default identity until the downloaded one takes over
      usbCtl.vendorId <= DEFAULT_VID; // [R12]
    end else if (portInitDeviceReset) begin
      usbCtl.connect <= 1'b0;
      usbCtl.downloadedId <= 1'b0;
    end else if (next_state == ST_DISC) begin
      usbCtl.connect <= 1'b0; // [R13]
      usbCtl.downloadedId <= 1'b1;
    end else if (state == ST_LOAD && src == bsr_pkg::SRC_USB) begin
      usbCtl.connect <= 1'b1; // [R12]
    end else if (state == ST_DISC && cntDone) begin
      usbCtl.connect <= 1'b1; // [R13]
    end
  end

  // ****************************************************************
  // Processor hold and firmware state
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      firmwareValid <= 1'b0;
    end else if (portInitDeviceReset) begin
      firmwareValid <= 1'b0; // [R11]
    end else if (state == ST_LOAD && loadRsp.done && !loadFail) begin
      firmwareValid <= 1'b1;
    end
  end

  // CPU-only reset holds the core briefly; image and state stay intact
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cpuRstCnt <= 4'h0;
    end else if (portInitCpuReset && state == ST_RUN) begin
      cpuRstCnt <= CPU_RST; // [R9] [R10]
    end else if (cpuRstCnt != 4'h0) begin
      cpuRstCnt <= cpuRstCnt - 4'h1;
    end
  end

  assign cpuHold = (state != ST_RUN) || (cpuRstCnt != 4'h0); // [R10]

endmodule

//--- rtl/bsr_pkg.sv
// Shared types and constants for the boot source select and reset block.
// Assumes one 25 MHz core clock and synchronous strap and loader inputs.
package bsr_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 25;
  localparam int STRAP_SETTLE_NS = 1000;
  localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int USB_DISC_NS = 10000;
  localparam int USB_DISC_CYC = (USB_DISC_NS * CLK_MHZ + 999) / 1000;
  localparam int CPU_RST_NS = 160;
  localparam int CPU_RST_CYC = (CPU_RST_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 9;

  // ****************************************************************
  // Strap levels and codes
  // ****************************************************************
  typedef enum logic [1:0] {
    LVL_LOW   = 2'h0,
    LVL_HIGH  = 2'h1,
    LVL_FLOAT = 2'h2
  } bsr_level_e;

  localparam logic [5:0] CODE_SYNC_MUX  = {LVL_FLOAT, LVL_LOW, LVL_LOW};
  localparam logic [5:0] CODE_ASYNC_MUX = {LVL_FLOAT, LVL_LOW, LVL_HIGH};
  localparam logic [5:0] CODE_USB       = {LVL_FLOAT, LVL_HIGH, LVL_HIGH};
  localparam logic [5:0] CODE_SRAM      = {LVL_FLOAT, LVL_LOW, LVL_FLOAT};
  localparam logic [5:0] CODE_I2C_USB   = {LVL_FLOAT, LVL_HIGH, LVL_FLOAT};
  localparam logic [5:0] CODE_I2C_ONLY  = {LVL_HIGH, LVL_FLOAT, LVL_FLOAT};
  localparam logic [5:0] CODE_SPI_USB   = {LVL_LOW, LVL_FLOAT, LVL_HIGH};

  // ****************************************************************
  // Boot sources
  // ****************************************************************
  typedef enum logic [2:0] {
    SRC_NONE      = 3'h0,
    SRC_SYNC_MUX  = 3'h1,
    SRC_ASYNC_MUX = 3'h2,
    SRC_SRAM      = 3'h3,
    SRC_USB       = 3'h4,
    SRC_I2C       = 3'h5,
    SRC_SPI       = 3'h6
  } bsr_src_e;

  // Supported serial flash densities in megabits
  localparam logic [4:0] SPI_MBIT_4 = 5'h04;
  localparam logic [4:0] SPI_MBIT_8 = 5'h08;
  localparam logic [4:0] SPI_MBIT_16 = 5'h10;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic start;
    bsr_src_e src;
  } bsr_load_req_s;

  typedef struct packed {
    logic done;
    logic fail;
    logic [4:0] spiMbit;
  } bsr_load_rsp_s;

  typedef struct packed {
    logic connect;
    logic downloadedId;
    logic [15:0] vendorId;
  } bsr_usb_s;

endpackage

//--- rtl/bsr_strap_sense.sv
// Three-level strap sensing: each pin is read under pull-up, then pull-down.
// Assumes the pad applies weak pulls from strapPullUp/strapPullDown.
`timescale 1ns/1ps

module bsr_strap_sense #(
  parameter int PINS = 3
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Phase control from the sequencer
  input wire logic phaseUp,
  input wire logic phaseDown,
  input wire logic sampleUp,
  input wire logic sampleDown,
  // Pads
  input wire logic [PINS-1:0] strapIn,
  output logic [PINS-1:0] strapPullUp,
  output logic [PINS-1:0] strapPullDown,
  // Decoded levels
  output logic [2*PINS-1:0] levels
);

  // ****************************************************************
  // Per pin sampling
  // ****************************************************************
  // A floating pin follows whichever pull is applied; a driven pin ignores it
  for (genvar i = 0; i < PINS; i++) begin : g_pin
    logic seenUp;
    logic seenDown;

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        seenUp <= 1'b0;
      end else if (sampleUp) begin
        seenUp <= strapIn[i];
      end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        seenDown <= 1'b0;
      end else if (sampleDown) begin
        seenDown <= strapIn[i];
      end
    end

    // One continuous driver per slice keeps each bit single-sourced
    assign levels[2*i+1:2*i] =
      (seenUp && !seenDown) ? bsr_pkg::LVL_FLOAT :
      (seenUp ? bsr_pkg::LVL_HIGH : bsr_pkg::LVL_LOW);

    assign strapPullUp[i] = phaseUp;
    assign strapPullDown[i] = phaseDown;
  end

endmodule

//--- test/bsr_boot_ctrl_chk.sv
// Checker for the boot sequencer: strap phases, fallback and resets.
// Assumes it is bound into bsr_boot_ctrl and sees only its ports.
`timescale 1ns/1ps

module bsr_boot_ctrl_chk #(
  parameter logic [15:0] DEFAULT_VID = 16'h1234,
  parameter int DISC_CYC = bsr_pkg::USB_DISC_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Straps
  input wire logic [2:0] strapIn,
  input wire logic [2:0] strapPullUp,
  input wire logic [2:0] strapPullDown,
  // Soft resets
  input wire logic portInitCpuReset,
  input wire logic portInitDeviceReset,
  // Loader and status
  input wire bsr_pkg::bsr_load_req_s loadReq,
  input wire bsr_pkg::bsr_load_rsp_s loadRsp,
  input wire logic i2cMasterOnly,
  input wire bsr_pkg::bsr_usb_s usbCtl,
  input wire logic cpuHold,
  input wire logic firmwareValid,
  input wire logic [5:0] bootCode,
  input wire logic bootHalted
);
  localparam int DISC_M1 = DISC_CYC - 1;
  logic [8:0] cyc;
  logic goodMbit;
  logic isSpi;
  logic fbReq;
  logic okDone;
  logic cpuGo;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Cycles since the last hard or whole-device reset, saturating
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cyc <= 9'h000;
    end else if (portInitDeviceReset) begin
      cyc <= 9'h000;
    end else if (cyc != 9'h1FF) begin
      cyc <= cyc + 9'h001;
    end
  end

  assign goodMbit = loadRsp.spiMbit inside {bsr_pkg::SPI_MBIT_4,
    bsr_pkg::SPI_MBIT_8, bsr_pkg::SPI_MBIT_16};
  assign isSpi = loadReq.src == bsr_pkg::SRC_SPI;
  assign fbReq = isSpi ? (loadRsp.fail || (loadRsp.done && !goodMbit)) :
    (loadRsp.fail && loadReq.src == bsr_pkg::SRC_I2C &&
     bootCode == bsr_pkg::CODE_I2C_USB);
  assign okDone = loadRsp.done && (isSpi ? goodMbit :
    loadReq.src inside {bsr_pkg::SRC_SYNC_MUX, bsr_pkg::SRC_ASYNC_MUX,
    bsr_pkg::SRC_SRAM, bsr_pkg::SRC_I2C});
  assign cpuGo = portInitCpuReset && firmwareValid && !cpuHold &&
    !portInitDeviceReset;

  property p_pull_up;
    cyc < 9'h019 |-> strapPullUp == 3'h7 && strapPullDown == 3'h0;
  endproperty
  a_pull_up: assert property (p_pull_up)
    else $error("pull-up phase wrong");

  property p_pull_down;
    cyc inside {[9'h019:9'h031]} |-> strapPullDown == 3'h7 && !strapPullUp;
  endproperty
  a_pull_down: assert property (p_pull_down)
    else $error("pull-down phase wrong");

  property p_code_held;
    cyc > 9'h033 |-> $stable(bootCode);
  endproperty
  a_code_held: assert property (p_code_held)
    else $error("boot code moved");

  property p_start;
    cyc == 9'h033 |-> loadReq.start || bootHalted;
  endproperty
  a_start: assert property (p_start)
    else $error("no load start after decode");

  property p_fallback;
    fbReq |=> loadReq.start && loadReq.src == bsr_pkg::SRC_USB;
  endproperty
  a_fallback: assert property (p_fallback)
    else $error("no fallback to usb");

  property p_i2c_halt;
    loadRsp.fail && bootCode == bsr_pkg::CODE_I2C_ONLY |=>
      bootHalted && !loadReq.start;
  endproperty
  a_i2c_halt: assert property (p_i2c_halt)
    else $error("i2c-only failure not halted");

  property p_done;
    okDone |=> firmwareValid && !cpuHold;
  endproperty
  a_done: assert property (p_done)
    else $error("load done not run");

  property p_i2c_master;
    i2cMasterOnly == (loadReq.src == bsr_pkg::SRC_I2C);
  endproperty
  a_i2c_master: assert property (p_i2c_master)
    else $error("i2c master flag wrong");

  property p_usb_attach;
    loadReq.start && loadReq.src == bsr_pkg::SRC_USB |=> usbCtl.connect &&
      !usbCtl.downloadedId && usbCtl.vendorId == DEFAULT_VID;
  endproperty
  a_usb_attach: assert property (p_usb_attach)
    else $error("usb attach wrong");

  property p_renum;
    loadRsp.done && loadReq.src == bsr_pkg::SRC_USB |=> !usbCtl.connect &&
      usbCtl.downloadedId ##DISC_M1 !usbCtl.connect ##1 usbCtl.connect;
  endproperty
  a_renum: assert property (p_renum)
    else $error("disconnect and reconnect wrong");

  property p_cpu_rst;
    cpuGo |=> (cpuHold && firmwareValid) [*4] ##1 !cpuHold;
  endproperty
  a_cpu_rst: assert property (p_cpu_rst)
    else $error("cpu reset wrong");

  property p_dev_rst;
    portInitDeviceReset |=> !firmwareValid && bootCode == 6'h00 &&
      cpuHold && strapPullUp == 3'h7;
  endproperty
  a_dev_rst: assert property (p_dev_rst)
    else $error("device reset wrong");

  c_renum: cover property (loadRsp.done && loadReq.src == bsr_pkg::SRC_USB);
  c_fallback: cover property (fbReq);
  c_cpu_rst: cover property (cpuGo);
endmodule

bind bsr_boot_ctrl bsr_boot_ctrl_chk #(
  .DEFAULT_VID(DEFAULT_VID),
  .DISC_CYC(DISC_CYC)
) u_chk (
  .mclk(mclk), .rst_n(rst_n), .strapIn(strapIn),
  .strapPullUp(strapPullUp), .strapPullDown(strapPullDown),
  .portInitCpuReset(portInitCpuReset),
  .portInitDeviceReset(portInitDeviceReset), .loadReq(loadReq),
  .loadRsp(loadRsp), .i2cMasterOnly(i2cMasterOnly), .usbCtl(usbCtl),
  .cpuHold(cpuHold), .firmwareValid(firmwareValid), .bootCode(bootCode),
  .bootHalted(bootHalted)
);

//--- test/bsr_far_side.sv
// Far-side model: three-level strap pads and the boot loader engines.
// Assumes one clock; each loader start gets exactly one answer pulse.
`timescale 1ns/1ps

module bsr_far_side (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Scenario control
  input wire logic [5:0] strapLvl,
  input wire logic [6:0] failMask,
  input wire logic [4:0] mbit,
  input wire logic slow,
  // Device side
  input wire logic [2:0] pullUp,
  input wire logic [2:0] pullDown,
  input wire bsr_pkg::bsr_load_req_s loadReq,
  output logic [2:0] strapIn,
  output bsr_pkg::bsr_load_rsp_s loadRsp
);
  logic [2:0] last;
  logic [3:0] cnt;
  logic [2:0] src;

  // An open pin with no pull wanders, so only the pulls define it
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      case (strapLvl[2*i+:2])
        2'h0: strapIn[i] = 1'b0;
        2'h1: strapIn[i] = 1'b1;
        default: strapIn[i] = pullUp[i] | (~pullDown[i] & ~last[i]);
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    last <= strapIn;
  end

  // Memory, EEPROM or USB host answer; density is junk off the pulse
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      src <= 3'h0;
      loadRsp <= '0;
    end else begin
      loadRsp <= {2'h0, ~mbit};
      if (loadReq.start) begin
        cnt <= slow ? 4'h8 : 4'h1;
        src <= loadReq.src;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
        if (cnt == 4'h1) begin
          loadRsp <= {~failMask[src], failMask[src], mbit};
        end
      end
    end
  end
endmodule

//--- test/testbench.sv
// Self-checking bench for the boot source select and reset block.
// Assumes the far-side model drives straps and answers loader starts.
`timescale 1ns/1ps

module testbench;
  typedef struct packed {
    logic [5:0] lvl;
    logic [6:0] fm;
    logic [4:0] mb;
    logic slow;
    logic [2:0] first;
    logic [2:0] last;
    logic ok;
    logic dl;
  } bsr_row_s;

  localparam logic [15:0] VID = 16'h5A5A; // arbitrary value
  logic mclk, rst_n, cpuRst, devRst, slow, i2cMasterOnly;
  logic cpuHold, firmwareValid, bootHalted;
  logic [5:0] strapLvl, bootCode;
  logic [6:0] failMask;
  logic [4:0] mbit;
  logic [2:0] strapIn, pullUp, pullDown, firstSrc, lastSrc;
  bsr_pkg::bsr_load_req_s loadReq;
  bsr_pkg::bsr_load_rsp_s loadRsp;
  bsr_pkg::bsr_usb_s usbCtl;
  int nStart, cycles, checks, miscompares;
  bsr_row_s rows [13] = '{
    '{bsr_pkg::CODE_SYNC_MUX, 7'h00, 5'h10, 1'b0, 3'h1, 3'h1, 1'b1, 1'b0},
    '{bsr_pkg::CODE_ASYNC_MUX, 7'h00, 5'h10, 1'b1, 3'h2, 3'h2, 1'b1, 1'b0},
    '{bsr_pkg::CODE_SRAM, 7'h00, 5'h10, 1'b0, 3'h3, 3'h3, 1'b1, 1'b0},
    '{bsr_pkg::CODE_USB, 7'h00, 5'h10, 1'b1, 3'h4, 3'h4, 1'b1, 1'b1},
    '{bsr_pkg::CODE_USB, 7'h10, 5'h10, 1'b0, 3'h4, 3'h4, 1'b0, 1'b0},
    '{bsr_pkg::CODE_I2C_USB, 7'h20, 5'h10, 1'b0, 3'h5, 3'h4, 1'b1, 1'b1},
    '{bsr_pkg::CODE_I2C_USB, 7'h30, 5'h10, 1'b0, 3'h5, 3'h4, 1'b0, 1'b0},
    '{bsr_pkg::CODE_I2C_ONLY, 7'h20, 5'h10, 1'b0, 3'h5, 3'h5, 1'b0, 1'b0},
    '{6'h00, 7'h00, 5'h10, 1'b0, 3'h0, 3'h0, 1'b0, 1'b0},
    '{bsr_pkg::CODE_SPI_USB, 7'h40, 5'h08, 1'b0, 3'h6, 3'h4, 1'b1, 1'b1},
    '{bsr_pkg::CODE_SPI_USB, 7'h00, 5'h05, 1'b0, 3'h6, 3'h4, 1'b1, 1'b1},
    '{bsr_pkg::CODE_SPI_USB, 7'h00, 5'h10, 1'b1, 3'h6, 3'h6, 1'b1, 1'b0},
    '{bsr_pkg::CODE_SPI_USB, 7'h00, 5'h04, 1'b0, 3'h6, 3'h6, 1'b1, 1'b0}
  };

  bsr_boot_ctrl #(.DEFAULT_VID(VID), .DISC_CYC(4)) dut (
    .mclk(mclk), .rst_n(rst_n), .strapIn(strapIn), .strapPullUp(pullUp),
    .strapPullDown(pullDown), .portInitCpuReset(cpuRst),
    .portInitDeviceReset(devRst), .loadReq(loadReq), .loadRsp(loadRsp),
    .i2cMasterOnly(i2cMasterOnly), .usbCtl(usbCtl), .cpuHold(cpuHold),
    .firmwareValid(firmwareValid), .bootCode(bootCode),
    .bootHalted(bootHalted));

  bsr_far_side far (
    .mclk(mclk), .rst_n(rst_n), .strapLvl(strapLvl), .failMask(failMask),
    .mbit(mbit), .slow(slow), .pullUp(pullUp), .pullDown(pullDown),
    .loadReq(loadReq), .strapIn(strapIn), .loadRsp(loadRsp));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Log of loader starts and the timeout guard, sampled mid-cycle
  always @(negedge mclk) begin
    cycles++;
    if (loadReq.start === 1'b1) begin
      firstSrc = (nStart == 0) ? loadReq.src : firstSrc;
      lastSrc = loadReq.src;
      nStart++;
    end
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic clr_log();
    nStart = 0;
    firstSrc = 3'h0;
    lastSrc = 3'h0;
  endtask

  task automatic dev_reset();
    devRst = 1'b1;
    @(negedge mclk);
    devRst = 1'b0;
    clr_log();
    chk(bootCode, 6'h00, "code after soft reset");
    chk(firmwareValid, 1'b0, "image after soft reset");
  endtask

  // Sequence ends in run or halt; a hang is a mismatch
  task automatic wait_done();
    int n;
    n = 0;
    while (!((firmwareValid === 1'b1 && cpuHold === 1'b0) ||
             bootHalted === 1'b1) && n < 400) begin
      @(negedge mclk);
      n++;
    end
    chk(16'(n < 400), 16'h0001, "sequence hung");
  endtask

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    cpuRst = 1'b0;
    devRst = 1'b0;
    slow = 1'b0;
    strapLvl = bsr_pkg::CODE_SYNC_MUX;
    failMask = 7'h00;
    mbit = 5'h10;
    clr_log();
    repeat (6) @(negedge mclk);
    chk(pullUp, 3'h7, "pulls in reset");
    chk(cpuHold, 1'b1, "cpu in reset");
    rst_n = 1'b1;
    foreach (rows[i]) begin
      strapLvl = rows[i].lvl;
      failMask = rows[i].fm;
      mbit = rows[i].mb;
      slow = rows[i].slow;
      dev_reset();
      wait_done();
      chk(bootCode, rows[i].lvl, "code");
      chk(firstSrc, rows[i].first, "source");
      chk(lastSrc, rows[i].last, "final source");
      chk(firmwareValid, rows[i].ok, "loaded");
      chk(bootHalted, !rows[i].ok, "halted");
      chk(usbCtl.downloadedId, rows[i].dl, "identity");
      chk(i2cMasterOnly, rows[i].last == 3'h5, "i2c");
      chk(usbCtl.vendorId, VID, "vendor");
    end
    // Only the processor restarts; the image stays
    cpuRst = 1'b1;
    @(negedge mclk);
    cpuRst = 1'b0;
    repeat (4) begin
      chk(cpuHold, 1'b1, "cpu held");
      chk(firmwareValid, 1'b1, "image kept");
      @(negedge mclk);
    end
    chk(cpuHold, 1'b0, "cpu released");
    // Hard reset in mid-load, then a strap change after sampling
    strapLvl = bsr_pkg::CODE_SYNC_MUX;
    slow = 1'b1;
    dev_reset();
    repeat (53) @(negedge mclk);
    rst_n = 1'b0;
    @(negedge mclk);
    chk(bootCode, 6'h00, "code in reset");
    chk(firmwareValid, 1'b0, "image in reset");
    clr_log();
    rst_n = 1'b1;
    repeat (52) @(negedge mclk);
    strapLvl = bsr_pkg::CODE_USB;
    wait_done();
    chk(bootCode, bsr_pkg::CODE_SYNC_MUX, "held code");
    chk(firstSrc, 3'h1, "held source");
    end_of_test();
  end
endmodule
